// file: hdl/anreg_top.sv
// negotiation status and next page transmit register slice
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`include "anreg_defs.svh"

module anreg_top #(
  parameter int ADDR_W = 5
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic [ADDR_W-1:0]     addr_in,
  input  wire logic [15:0]           wr_data_in,
  input  wire logic                  wr_en_in,
  input  wire logic                  rd_en_in,
  output logic      [15:0]           rd_data_out,
  input  wire logic                  partner_word_valid_in,
  input  wire anreg_pkg::anreg_partner_s partner_word_in,
  input  wire logic                  page_received_in,
  input  wire logic                  parallel_detect_fault_in,
  input  wire logic                  comply_acknowledge_in,
  input  wire logic                  page_exchanged_in,
  input  wire logic                  exchanged_toggle_in,
  output logic      [15:0]           next_page_word_out,
  output logic                       more_pages_wanted_out,
  output logic                       irq_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  anreg_pkg::anreg_state_s st_r;
  anreg_pkg::anreg_state_s st_nxt;
  logic [15:0]             partner_word;
  logic [15:0]             expansion_word;
  logic [15:0]             next_page_word;
  logic [15:0]             irq_word;
  logic [15:0]             mask_word;
  logic                    pdf_rise;
  logic                    pdf_d_r;

  // ----------------------------------------------------------------
  // read views; unlisted bits stay zero
  // ----------------------------------------------------------------
  always_comb begin
    partner_word = `ANREG_ZERO16;
    partner_word[`ANREG_PA_HALF10_BIT] = st_r.partner.half10;
    partner_word[`ANREG_PA_SEL_HI:`ANREG_PA_SEL_LO] =
      st_r.partner.partner_selector_field;

    expansion_word = `ANREG_ZERO16;
    expansion_word[`ANREG_EX_PDF_BIT]    = parallel_detect_fault_in;
    expansion_word[`ANREG_EX_LPNP_BIT]   = st_r.partner.partner_next_page_capable;
    expansion_word[`ANREG_EX_NPABLE_BIT] = 1'b1;
    expansion_word[`ANREG_EX_PAGERX_BIT] = st_r.page_rx;
    expansion_word[`ANREG_EX_LPAN_BIT]   = st_r.partner.partner_negotiation_capable;

    next_page_word = `ANREG_ZERO16;
    next_page_word[`ANREG_NP_MORE_BIT] = st_r.more_pages_wanted;
    next_page_word[`ANREG_NP_RSVD_BIT] = 1'b0;
    next_page_word[`ANREG_NP_MSG_BIT]  = `ANREG_RST_MSG;
    next_page_word[`ANREG_NP_COMPLY_ACKNOWLEDGE_BIT] = st_r.comply_acknowledge;
    next_page_word[`ANREG_NP_TOG_BIT]  = st_r.page_toggle_bit;
    next_page_word[`ANREG_NP_CODE_HI:`ANREG_NP_CODE_LO] = `ANREG_RST_CODE;

    irq_word       = {13'h0000, st_r.irq_status};
    mask_word      = {13'h0000, st_r.irq_mask};
  end

  // fault is a level; only its rising edge counts as an interrupt event
  assign pdf_rise = parallel_detect_fault_in & ~pdf_d_r;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_data = `ANREG_ZERO16;
    st_nxt.comply_acknowledge = comply_acknowledge_in;

    if (partner_word_valid_in) begin
      st_nxt.partner = partner_word_in;
    end
    if (page_exchanged_in) begin
      st_nxt.page_toggle_bit = ~exchanged_toggle_in;
    end

    // only the more pages bit and the mask take writes
    if (wr_en_in && hit(addr_in, `ANREG_OFS_NEXT_PAGE)) begin
      st_nxt.more_pages_wanted = wr_data_in[`ANREG_NP_MORE_BIT];
    end
    if (wr_en_in && hit(addr_in, `ANREG_OFS_IRQ_MASK)) begin
      st_nxt.irq_mask = wr_data_in[2:0];
    end

    if (rd_en_in) begin
      unique case (1'b1)
        hit(addr_in, `ANREG_OFS_PARTNER):    st_nxt.rd_data = partner_word;
        hit(addr_in, `ANREG_OFS_EXPANSION):  st_nxt.rd_data = expansion_word;
        hit(addr_in, `ANREG_OFS_NEXT_PAGE):  st_nxt.rd_data = next_page_word;
        hit(addr_in, `ANREG_OFS_IRQ_STATUS): st_nxt.rd_data = irq_word;
        hit(addr_in, `ANREG_OFS_IRQ_MASK):   st_nxt.rd_data = mask_word;
        default:                             st_nxt.rd_data = `ANREG_ZERO16;
      endcase
    end

    // clear on read first, so a same-cycle event still lands
    if (rd_en_in && hit(addr_in, `ANREG_OFS_EXPANSION)) begin
      st_nxt.page_rx = 1'b0;
    end
    if (page_received_in) begin
      st_nxt.page_rx = 1'b1;
    end

    if (rd_en_in && hit(addr_in, `ANREG_OFS_IRQ_STATUS)) begin
      st_nxt.irq_status = `ANREG_RST_IRQ;
    end
    if (page_received_in) begin
      st_nxt.irq_status[`ANREG_IRQ_PAGE_BIT] = 1'b1;
    end
    if (pdf_rise) begin
      st_nxt.irq_status[`ANREG_IRQ_PDF_BIT] = 1'b1;
    end
    if (partner_word_valid_in) begin
      st_nxt.irq_status[`ANREG_IRQ_WORD_BIT] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r.partner.half10                      <= 1'b0;
      st_r.partner.partner_selector_field      <= `ANREG_RST_SEL;
      st_r.partner.partner_next_page_capable   <= 1'b0;
      st_r.partner.partner_negotiation_capable <= 1'b0;
      st_r.page_rx                             <= 1'b0;
      st_r.more_pages_wanted                   <= `ANREG_RST_MORE;
      st_r.comply_acknowledge                  <= 1'b0;
      st_r.page_toggle_bit                     <= 1'b0;
      st_r.irq_status                          <= `ANREG_RST_IRQ;
      st_r.irq_mask                            <= `ANREG_RST_IRQ;
      st_r.rd_data                             <= `ANREG_ZERO16;
      pdf_d_r                                  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      pdf_d_r <= parallel_detect_fault_in;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_data_out           = st_r.rd_data;
  assign next_page_word_out    = next_page_word;
  assign more_pages_wanted_out = st_r.more_pages_wanted;
  assign irq_out               = |(st_r.irq_status & st_r.irq_mask);

endmodule

// file: pkg/anreg_defs.svh
// register offsets, field positions, reset values for the negotiation register slice
`ifndef ANREG_DEFS_SVH
`define ANREG_DEFS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define ANREG_OFS_PARTNER    5'h05
`define ANREG_OFS_EXPANSION  5'h06
`define ANREG_OFS_NEXT_PAGE  5'h07
`define ANREG_OFS_IRQ_STATUS 5'h10
`define ANREG_OFS_IRQ_MASK   5'h11

// ----------------------------------------------------------------
// partner ability fields
// ----------------------------------------------------------------
`define ANREG_PA_HALF10_BIT  5
`define ANREG_PA_SEL_HI      4
`define ANREG_PA_SEL_LO      0

// ----------------------------------------------------------------
// expansion fields
// ----------------------------------------------------------------
`define ANREG_EX_PDF_BIT     4
`define ANREG_EX_LPNP_BIT    3
`define ANREG_EX_NPABLE_BIT  2
`define ANREG_EX_PAGERX_BIT  1
`define ANREG_EX_LPAN_BIT    0

// ----------------------------------------------------------------
// next page transmit fields
// ----------------------------------------------------------------
`define ANREG_NP_MORE_BIT    15
`define ANREG_NP_RSVD_BIT    14
`define ANREG_NP_MSG_BIT     13
`define ANREG_NP_COMPLY_ACKNOWLEDGE_BIT    12
`define ANREG_NP_TOG_BIT     11
`define ANREG_NP_CODE_HI     10
`define ANREG_NP_CODE_LO     0

// ----------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------
`define ANREG_IRQ_PAGE_BIT   0
`define ANREG_IRQ_PDF_BIT    1
`define ANREG_IRQ_WORD_BIT   2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ANREG_RST_SEL        5'h00
`define ANREG_RST_MORE       1'h1
`define ANREG_RST_MSG        1'h1
`define ANREG_RST_CODE       11'h008
`define ANREG_RST_IRQ        3'h0
`define ANREG_ZERO16         16'h0000

`endif

// file: pkg/anreg_pkg.sv
// types shared by the negotiation register slice
package anreg_pkg;

  // ----------------------------------------------------------------
  // partner word from the negotiation engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       half10;
    logic [4:0] partner_selector_field;
    logic       partner_next_page_capable;
    logic       partner_negotiation_capable;
  } anreg_partner_s;

  // ----------------------------------------------------------------
  // all state of the register slice except the fault delay flop pdf_d_r
  // ----------------------------------------------------------------
  typedef struct packed {
    anreg_partner_s partner;
    logic           page_rx;
    logic           more_pages_wanted;
    logic           comply_acknowledge;
    logic           page_toggle_bit;
    logic [2:0]     irq_status;
    logic [2:0]     irq_mask;
    logic [15:0]    rd_data;
  } anreg_state_s;

endpackage

// file: tb/anreg_top_assertions.sv
// concurrent checks on the negotiation register slice ports
`timescale 1ns/10ps
module anreg_top_chk (
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  input wire logic [4:0]  addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic        wr_en_in,
  input wire logic        rd_en_in,
  input wire logic [15:0] rd_data_out,
  input wire logic        page_received_in,
  input wire logic        parallel_detect_fault_in,
  input wire logic        comply_acknowledge_in,
  input wire logic        page_exchanged_in,
  input wire logic        exchanged_toggle_in,
  input wire logic [15:0] next_page_word_out,
  input wire logic        more_pages_wanted_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_resv; $past(rd_en_in) && $past(addr_in) == 5'h06 |-> rd_data_out[15:5] == 11'h000;
  endproperty
  a_resv: assert property (p_resv) else $error("expansion reserved bits set");
  property p_np_resv; next_page_word_out[14] == 1'h0; endproperty
  a_np_resv: assert property (p_np_resv) else $error("next page bit 14 set");
  property p_able; $past(rd_en_in) && $past(addr_in) == 5'h06 |-> rd_data_out[2]; endproperty
  a_able: assert property (p_able) else $error("extra pages bit low");
  property p_pdf; $past(rd_en_in) && $past(addr_in) == 5'h06
    |-> rd_data_out[4] == $past(parallel_detect_fault_in); endproperty
  a_pdf: assert property (p_pdf) else $error("fault bit wrong");
  property p_clr; rd_en_in && addr_in == 5'h06 && !page_received_in ##1 !page_received_in
    ##1 rd_en_in && addr_in == 5'h06 |=> !rd_data_out[1]; endproperty
  a_clr: assert property (p_clr) else $error("page flag not cleared");
  property p_more; wr_en_in && addr_in == 5'h07 |=> more_pages_wanted_out == $past(wr_data_in[15])
    && next_page_word_out[15] == more_pages_wanted_out; endproperty
  a_more: assert property (p_more) else $error("more pages bit not written");
  property p_const; next_page_word_out[13] && next_page_word_out[10:0] == 11'h008; endproperty
  a_const: assert property (p_const) else $error("message flag or code wrong");
  property p_comply_acknowledge; next_page_word_out[12] == $past(comply_acknowledge_in); endproperty
  a_comply_acknowledge: assert property (p_comply_acknowledge) else $error("comply bit wrong");
  property p_tog; page_exchanged_in |=> next_page_word_out[11] == !$past(exchanged_toggle_in);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle not inverted");
endmodule
bind anreg_top anreg_top_chk u_anreg_top_chk (.*);

// file: tb/anreg_lp_model.sv
// remote link partner model driving the negotiation inputs
`timescale 1ns/10ps
module anreg_lp_model (
  input  wire logic                 sys_clk_in,
  output logic                      word_valid_out,
  output anreg_pkg::anreg_partner_s word_out,
  output logic                      page_out,
  output logic                      xchg_out,
  output logic                      tog_out
);
  initial {word_valid_out, word_out, page_out, xchg_out, tog_out} = '0;
  // word is junk outside its pulse, so a late capture shows up
  task automatic send(input anreg_pkg::anreg_partner_s w);
    @(posedge sys_clk_in);
    {word_valid_out, page_out, word_out} <= {2'h3, w};
    @(posedge sys_clk_in);
    {word_valid_out, page_out, word_out} <= {2'h0, ~w};
  endtask
  task automatic exch(input logic t);
    @(posedge sys_clk_in);
    {xchg_out, tog_out} <= {1'h1, t};
    @(posedge sys_clk_in);
    {xchg_out, tog_out} <= {1'h0, ~t};
  endtask
endmodule

// file: tb/anreg_top_tb_top.sv
// self-checking bench for the negotiation register slice
`timescale 1ns/10ps
module anreg_top_tb_top;
  logic                      sys_clk_in = 1'h0;
  logic                      rst_n_in = 1'h0;
  logic [4:0]                addr_in = 5'h00;
  logic [15:0]               wr_data_in = 16'h0000;
  logic                      wr_en_in = 1'h0;
  logic                      rd_en_in = 1'h0;
  logic                      parallel_detect_fault_in = 1'h0;
  logic                      comply_acknowledge_in = 1'h0;
  logic                      partner_word_valid_in, page_received_in;
  logic                      page_exchanged_in, exchanged_toggle_in;
  anreg_pkg::anreg_partner_s partner_word_in;
  logic [15:0]               rd_data_out, next_page_word_out;
  logic                      more_pages_wanted_out, irq_out;
  int                        errors = 0;
  int                        n_checks = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  anreg_top u_anreg_top (.*);
  anreg_lp_model u_anreg_lp_model (.sys_clk_in(sys_clk_in), .word_valid_out(partner_word_valid_in),
    .word_out(partner_word_in), .page_out(page_received_in), .xchg_out(page_exchanged_in),
    .tog_out(exchanged_toggle_in));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    {wr_en_in, addr_in, wr_data_in} <= {1'h1, a, d};
    @(posedge sys_clk_in);
    wr_en_in <= 1'h0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    @(posedge sys_clk_in);
    {rd_en_in, addr_in} <= {1'h1, a};
    @(posedge sys_clk_in);
    rd_en_in <= 1'h0;
    #1 chk(rd_data_out, exp);
  endtask
  task automatic t_reset;
    rdc(5'h05, 16'h0000);
    rdc(5'h06, 16'h0004);
    rdc(5'h07, 16'hA008);
    chk(next_page_word_out, 16'hA008);
    chk({15'h0000, more_pages_wanted_out}, 16'h0001);
    $display("t_reset done");
  endtask
  task automatic t_partner;
    u_anreg_lp_model.send(8'hD7);
    rdc(5'h05, 16'h0035);
    rdc(5'h06, 16'h000F);
    rdc(5'h06, 16'h000D);
    @(posedge sys_clk_in);
    parallel_detect_fault_in <= 1'h1;
    rdc(5'h06, 16'h001D);
    @(posedge sys_clk_in);
    parallel_detect_fault_in <= 1'h0;
    rdc(5'h06, 16'h000D);
    $display("t_partner done");
  endtask
  task automatic t_write;
    wr(5'h05, 16'hFFFF);
    wr(5'h06, 16'hFFFF);
    wr(5'h07, 16'h0000);
    rdc(5'h05, 16'h0035);
    rdc(5'h06, 16'h000D);
    rdc(5'h07, 16'h2008);
    chk({15'h0000, more_pages_wanted_out}, 16'h0000);
    wr(5'h07, 16'hFFFF);
    rdc(5'h07, 16'hA008);
    $display("t_write done");
  endtask
  task automatic t_np;
    @(posedge sys_clk_in);
    comply_acknowledge_in <= 1'h1;
    u_anreg_lp_model.exch(1'h1);
    rdc(5'h07, 16'hB008);
    u_anreg_lp_model.exch(1'h0);
    rdc(5'h07, 16'hB808);
    chk(next_page_word_out, 16'hB808);
    $display("t_np done");
  endtask
  // status bits left from earlier tests: page, fault rise, word
  task automatic t_irq;
    rdc(5'h10, 16'h0007);
    wr(5'h11, 16'h0001);
    u_anreg_lp_model.send(8'h00);
    @(posedge sys_clk_in);
    #1 chk({15'h0000, irq_out}, 16'h0001);
    wr(5'h11, 16'h0000);
    #1 chk({15'h0000, irq_out}, 16'h0000);
    rdc(5'h10, 16'h0005);
    wr(5'h11, 16'h0007);
    #1 chk({15'h0000, irq_out}, 16'h0000);
    rdc(5'h1F, 16'h0000);
    $display("t_irq done");
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_n_in <= 1'h1;
    t_reset;
    t_partner;
    t_write;
    t_np;
    t_irq;
    results;
  end
  initial begin
    #20000;
    errors++;
    results;
  end
endmodule
